// ==== core/bbc_pkg.sv ====
// shared constants and types for the branch, bit and call decoder
package bbc_pkg;

  // ------------------------------------------------------------------
  // opcode patterns
  // ------------------------------------------------------------------
  localparam logic [4:0] OP_REL_JUMP_ALWAYS = 5'h1a;  // 1101 0
  localparam logic [7:0] OP_JUMP_ON_ZERO    = 8'he0;
  localparam logic [7:0] OP_JUMP_ON_OVF     = 8'he4;
  localparam logic [6:0] OP_CALL_FIRST      = 7'h76;  // 1110 110
  localparam logic [3:0] OP_CALL_SECOND     = 4'hf;
  localparam logic [3:0] OP_BIT_FORCE_ONE   = 4'h8;
  localparam logic [3:0] OP_BIT_INVERT      = 4'h7;
  localparam logic [3:0] OP_SKIP_WHEN_ZERO  = 4'hb;
  localparam logic [3:0] OP_SKIP_WHEN_ONE   = 4'ha;

  // ------------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------------
  localparam int          PC_W       = 21;
  localparam logic [20:0] PC_RST     = 21'h000000;
  localparam logic [3:0]  ACCESS_BANK = 4'h0;
  localparam logic [20:0] CALL_RET_OFS = 21'h000004;

  // quarter-cycle phases of one instruction cycle
  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } quarter_t;

  // decoded operation of the instruction in execution
  typedef enum logic [3:0] {
    OP_NONE      = 4'h0,
    OP_JMP       = 4'h1,
    OP_JZ        = 4'h2,
    OP_JOV       = 4'h3,
    OP_BSET      = 4'h4,
    OP_BINV      = 4'h5,
    OP_SKIP0     = 4'h6,
    OP_SKIP1     = 4'h7,
    OP_CALL      = 4'h8
  } op_t;

endpackage : bbc_pkg

// ==== core/file_bus_if.sv ====
// data-memory access path between the decoder and its bit unit
interface file_bus_if;
  logic [11:0] addr;
  logic [7:0]  rdata;
  logic [2:0]  bit_sel;
  logic        do_set;
  logic        do_inv;
  logic [7:0]  wdata;
  logic        bit_val;

  modport ctrl (output addr, output bit_sel, output do_set, output do_inv,
                input wdata, input bit_val, input rdata);
  modport unit (input addr, input bit_sel, input do_set, input do_inv,
                input rdata, output wdata, output bit_val);
endinterface : file_bus_if

// ==== core/bit_unit.sv ====
// bit modify and test unit for banked file registers
module bit_unit (
  file_bus_if.unit fb
);
  // ------------------------------------------------------------------
  // modify and test
  // ------------------------------------------------------------------
  logic [7:0] mask;

  always_comb begin
    mask = 8'h01 << fb.bit_sel;
    fb.bit_val = |(fb.rdata & mask);
    if (fb.do_set) begin
      fb.wdata = fb.rdata | mask;
    end else if (fb.do_inv) begin
      fb.wdata = fb.rdata ^ mask;
    end else begin
      fb.wdata = fb.rdata;
    end
  end
endmodule // bit_unit

// ==== core/pc_adder.sv ====
// relative target adder for word-aligned branch targets
module pc_adder
  import bbc_pkg::*;
(
  input  wire logic [PC_W-1:0] pc_i,
  input  wire logic [10:0]     ofs_i,
  output logic      [PC_W-1:0] target_o
);
  // ------------------------------------------------------------------
  // sign-extended word offset, bit 0 kept clear
  // ------------------------------------------------------------------
  logic [PC_W-1:0] ofs_ext;

  always_comb begin
    ofs_ext  = {{(PC_W-12){ofs_i[10]}}, ofs_i, 1'b0};
    target_o = {pc_i[PC_W-1:1] + ofs_ext[PC_W-1:1], 1'b0};
  end
endmodule // pc_adder

// ==== core/branch_bit_call_decode.sv ====
// decode and execute for relative jumps, file bit ops and subroutine call
// How it works
// - rel_jump_always: prefix 11010, 11-bit signed offset, always two cycles
// - taken relative jump goes to fetched address plus twice offset
// - jump_on_overflow e4 jumps only with overflow set; 2 or 1 cycles
// - jump_on_zero e0 jumps only with zero set; extra cycle idle
// - none of these instructions touches arithmetic status flags
// - file_bit_force_one: read in Q2, write bit one in Q4
// - access flag zero picks access bank, one picks bank_select_reg
// - file_bit_invert flips the selected bit by read-modify-write
// - skip flushes fetched word; two-word victim costs another idle cycle
// - call: first word 1110110s with k7:0, second 1111 with k19:8
// - call pushes own address plus four onto return stack
// - fast call copies working, flags and bank select into shadows
// - call loads k into pc 20:1 in Q4 of the second-word cycle, pushes in Q3, third cycle idle
module branch_bit_call_decode
  import bbc_pkg::*;
(
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // instruction stream (same clock)
  input  wire logic [15:0]     instr_i,
  input  wire logic            instr_valid_i,
  // core state
  input  wire logic            flag_zero_i,
  input  wire logic            flag_ovf_i,
  input  wire logic [7:0]      working_i,
  input  wire logic [7:0]      flags_i,
  input  wire logic [3:0]      bank_select_reg_i,
  // data memory
  input  wire logic [7:0]      file_rdata_i,
  output logic      [11:0]     file_addr_o,
  output logic                 file_rd_o,
  output logic                 file_we_o,
  output logic      [7:0]      file_wdata_o,
  // program flow
  output logic      [PC_W-1:0] pc_o,
  output logic                 flush_o,
  output logic                 stack_push_o,
  output logic      [PC_W-1:0] return_stack_top_o,
  output logic      [1:0]      quarter_o,
  // shadows and status
  output logic      [7:0]      working_shadow_o,
  output logic      [7:0]      flags_shadow_o,
  output logic      [3:0]      bank_select_shadow_o,
  output logic                 status_we_o
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  quarter_t        q_ff;
  op_t             op_ff;
  logic [15:0]     ir_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] tos_ff;
  logic [1:0]      idle_ff;      // forced no-operation cycles pending
  logic            skip_arm_ff;  // flush next word, check for two-word
  logic            call2_ff;     // awaiting call second word
  logic            fast_ff;
  logic [7:0]      k_lo_ff;
  logic [7:0]      wdata_ff;
  logic            bit_ff;
  logic            we_ff;
  logic            push_ff;
  logic            flush_ff;
  logic [7:0]      ws_ff;
  logic [7:0]      ss_ff;
  logic [3:0]      bs_ff;

  file_bus_if fb ();
  logic [PC_W-1:0] rel_tgt;
  logic [10:0]     rel_ofs;
  logic            op_start;
  op_t             nxt_op;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  always_comb begin
    nxt_op = OP_NONE;
    if (instr_i[15:11] == OP_REL_JUMP_ALWAYS) begin
      nxt_op = OP_JMP;
    end else if (instr_i[15:8] == OP_JUMP_ON_ZERO) begin
      nxt_op = OP_JZ;
    end else if (instr_i[15:8] == OP_JUMP_ON_OVF) begin
      nxt_op = OP_JOV;
    end else if (instr_i[15:9] == OP_CALL_FIRST) begin
      nxt_op = OP_CALL;
    end else if (instr_i[15:12] == OP_BIT_FORCE_ONE) begin
      nxt_op = OP_BSET;
    end else if (instr_i[15:12] == OP_BIT_INVERT) begin
      nxt_op = OP_BINV;
    end else if (instr_i[15:12] == OP_SKIP_WHEN_ZERO) begin
      nxt_op = OP_SKIP0;
    end else if (instr_i[15:12] == OP_SKIP_WHEN_ONE) begin
      nxt_op = OP_SKIP1;
    end
  end

  // a new word is taken at Q1 unless idle cycles or a call tail are due
  assign op_start = (q_ff == Q1) && instr_valid_i && (idle_ff == 2'b00)
                    && !call2_ff;

  // ------------------------------------------------------------------
  // quarter sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_ff <= Q1;
    end else begin
      q_ff <= quarter_t'(q_ff + 2'b01);
    end
  end

  // ------------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_ff <= OP_NONE;
      ir_ff <= 16'h0000;
    end else if (q_ff == Q1) begin
      ir_ff <= instr_i;
      op_ff <= op_start ? nxt_op : OP_NONE;
    end
  end

  // ------------------------------------------------------------------
  // file access path
  // ------------------------------------------------------------------
  // bank from access flag
  assign fb.addr    = {ir_ff[8] ? bank_select_reg_i : ACCESS_BANK,
                       ir_ff[7:0]};
  assign fb.bit_sel = ir_ff[11:9];
  assign fb.do_set  = (op_ff == OP_BSET);
  assign fb.do_inv  = (op_ff == OP_BINV);
  assign fb.rdata   = file_rdata_i;

  bit_unit u_bit (
    .fb (fb)
  );

  // read in Q2, hold result for the Q4 write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdata_ff <= 8'h00;
      bit_ff   <= 1'b0;
      we_ff    <= 1'b0;
    end else begin
      if (q_ff == Q2) begin
        wdata_ff <= fb.wdata;
        bit_ff   <= fb.bit_val;
      end
      we_ff <= (q_ff == Q3) && (fb.do_set || fb.do_inv);
    end
  end

  // ------------------------------------------------------------------
  // program counter and flow control
  // ------------------------------------------------------------------
  // sign-extended offset; narrow branches use 8 bits
  assign rel_ofs = (op_ff == OP_JMP) ? ir_ff[10:0]
                                     : {{3{ir_ff[7]}}, ir_ff[7:0]};

  pc_adder u_add (
    .pc_i     (pc_ff),
    .ofs_i    (rel_ofs),
    .target_o (rel_tgt)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_ff       <= PC_RST;
      idle_ff     <= 2'b00;
      skip_arm_ff <= 1'b0;
      call2_ff    <= 1'b0;
      flush_ff    <= 1'b0;
    end else begin
      // flush is a one-clock pulse; the fetcher drops the word it holds
      // and the idle cycle below keeps the decoder from taking it anyway
      flush_ff <= 1'b0;
      // pc tracks the fetch: advance one word per cycle at Q1
      if (q_ff == Q1) begin
        pc_ff <= pc_ff + 21'h000002;
        if (idle_ff != 2'b00) begin
          idle_ff <= idle_ff - 2'b01;
        end
        // skipped word that is a call costs one more idle cycle
        if (skip_arm_ff) begin
          skip_arm_ff <= 1'b0;
          if (instr_i[15:9] == OP_CALL_FIRST) begin
            idle_ff <= 2'b01;
          end
        end
      end
      // taken branch writes pc in Q4, then idles
      if (q_ff == Q4) begin
        if ((op_ff == OP_JMP) || (op_ff == OP_JZ && flag_zero_i)
            || (op_ff == OP_JOV && flag_ovf_i)) begin
          pc_ff    <= rel_tgt;
          idle_ff  <= 2'b01;
          flush_ff <= 1'b1;
        end
        if ((op_ff == OP_SKIP0 && !bit_ff)
            || (op_ff == OP_SKIP1 && bit_ff)) begin
          idle_ff     <= 2'b01;
          skip_arm_ff <= 1'b1;
          flush_ff    <= 1'b1;
        end
        // second word arrives next cycle, then pc loads k
        if (op_ff == OP_CALL) begin
          call2_ff <= 1'b1;
        end
      end
      // second word supplies k19:8; target word aligned
      if (q_ff == Q4 && call2_ff) begin
        call2_ff <= 1'b0;
        if (ir_ff[15:12] == OP_CALL_SECOND) begin
          pc_ff    <= {ir_ff[11:0], k_lo_ff, 1'b0};
          idle_ff  <= 2'b01;
          flush_ff <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // call operand capture
  // ------------------------------------------------------------------
  // k7:0 and the fast bit come with the first word; they must survive a
  // whole instruction cycle until the second word supplies k19:8
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_ff <= 1'b0;
      k_lo_ff <= 8'h00;
    end else if (op_start && (nxt_op == OP_CALL)) begin
      fast_ff <= instr_i[8];
      k_lo_ff <= instr_i[7:0];
    end
  end

  // ------------------------------------------------------------------
  // return stack top
  // ------------------------------------------------------------------
  // push call address plus four in Q3
  // pc already points one word past the call, so one word less is added;
  // the push is a one-clock pulse and tos holds until the next call
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tos_ff  <= PC_RST;
      push_ff <= 1'b0;
    end else begin
      push_ff <= (q_ff == Q3) && (op_ff == OP_CALL);
      if ((q_ff == Q3) && (op_ff == OP_CALL)) begin
        tos_ff <= pc_ff + CALL_RET_OFS - 21'h000002;
      end
    end
  end

  // ------------------------------------------------------------------
  // shadow registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ws_ff <= 8'h00;
      ss_ff <= 8'h00;
      bs_ff <= 4'h0;
    end else if (q_ff == Q3 && op_ff == OP_CALL && fast_ff) begin
      ws_ff <= working_i;
      ss_ff <= flags_i;
      bs_ff <= bank_select_reg_i;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign file_addr_o          = fb.addr;
  assign file_rd_o            = (q_ff == Q2) && (op_ff inside {OP_BSET,
                                OP_BINV, OP_SKIP0, OP_SKIP1});
  assign file_we_o            = we_ff;
  assign file_wdata_o         = wdata_ff;
  assign pc_o                 = pc_ff;
  assign flush_o              = flush_ff;
  assign stack_push_o         = push_ff;
  assign return_stack_top_o   = tos_ff;
  assign quarter_o            = q_ff;
  assign working_shadow_o     = ws_ff;
  assign flags_shadow_o       = ss_ff;
  assign bank_select_shadow_o = bs_ff;
  assign status_we_o          = 1'b0;

endmodule // branch_bit_call_decode

// ==== testbench/branch_bit_call_decode_sva.sv ====
// port assertions for the branch, bit and call decoder
module branch_bit_call_decode_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        nrst_i,
  // watched outputs
  input wire logic        file_rd_o,
  input wire logic        file_we_o,
  input wire logic [11:0] file_addr_o,
  input wire logic [20:0] pc_o,
  input wire logic        flush_o,
  input wire logic        stack_push_o,
  input wire logic [20:0] return_stack_top_o,
  input wire logic [1:0]  quarter_o,
  input wire logic        status_we_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ------------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------------
  sequence s_read_write;
    file_rd_o ##2 file_we_o;
  endsequence
  sequence s_push;
    stack_push_o && quarter_o == 2'h3;
  endsequence

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // past reset guard: the first edge after release still sees reset values
  a_quarter_step: assert property ($past(nrst_i) |->
    quarter_o == $past(quarter_o) + 2'h1) else $error("quarter skipped");
  a_pc_aligned: assert property (pc_o[0] == 1'b0)
    else $error("pc bit zero set");
  a_status_quiet: assert property (!status_we_o)
    else $error("status written");
  a_read_in_q2: assert property (file_rd_o |-> quarter_o == 2'h1)
    else $error("file read outside second quarter");
  a_write_in_q4: assert property (s_read_write |->
    quarter_o == 2'h3 && file_addr_o == $past(file_addr_o, 2))
    else $error("write quarter or address wrong");
  a_write_after_read: assert property (file_we_o |->
    $past(file_rd_o, 2)) else $error("write without read");
  a_push_return: assert property (stack_push_o |->
    return_stack_top_o == pc_o + 21'h2) else $error("return address wrong");
  a_call_flush: assert property (stack_push_o |-> s_push ##5 flush_o)
    else $error("call push or target timing wrong");
  a_flush_idle: assert property (flush_o |-> quarter_o == 2'h0
    ##0 (!file_rd_o && !stack_push_o) [*4]) else $error("idle cycle busy");
endmodule // branch_bit_call_decode_sva

// ==== testbench/branch_bit_call_decode_tb.sv ====
// self-checking bench for the branch, bit and call decoder
module branch_bit_call_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bbc_pkg::*;

  // ------------------------------------------------------------------
  // signals and case table
  // ------------------------------------------------------------------
  logic            clk_i, nrst_i, instr_valid_i, flag_zero_i, flag_ovf_i;
  logic            file_rd_o, file_we_o, flush_o, stack_push_o, status_we_o;
  logic            rd_s, we_s, push_s, end_fl;
  logic [15:0]     instr_i;
  logic [7:0]      working_i, flags_i, file_rdata_i, file_wdata_o, wd_s;
  logic [7:0]      working_shadow_o, flags_shadow_o;
  logic [3:0]      bank_select_reg_i, bank_select_shadow_o;
  logic [11:0]     file_addr_o, addr_s;
  logic [1:0]      quarter_o;
  logic [PC_W-1:0] pc_o, return_stack_top_o, pc1, end_pc, tos_s, p;
  int              errors, num_checks;
  typedef struct {
    logic [15:0] w;
    logic [7:0]  rd;
    logic        z, ov, erd;
    logic [11:0] addr;
    logic        we;
    logic [7:0]  wd;
    logic        fl;
    logic [20:0] pcd;
  } row_t;
  row_t rows [13] = '{
    '{16'h8e0a, 8'h0a, 0, 0, 1, 12'h00a, 1, 8'h8a, 0, 0},
    '{16'h8133, 8'hfe, 0, 0, 1, 12'h533, 1, 8'hff, 0, 0},
    '{16'h7881, 8'h75, 0, 0, 1, 12'h081, 1, 8'h65, 0, 0},
    '{16'hb220, 8'h00, 0, 0, 1, 12'h020, 0, 8'h00, 1, 0},
    '{16'hb220, 8'h02, 0, 0, 1, 12'h020, 0, 8'h00, 0, 0},
    '{16'ha320, 8'h02, 0, 0, 1, 12'h520, 0, 8'h00, 1, 0},
    '{16'ha320, 8'hfd, 0, 0, 1, 12'h520, 0, 8'h00, 0, 0},
    '{16'hd3ff, 8'h00, 0, 0, 0, 12'h000, 0, 8'h00, 1, 21'h0007fe},
    '{16'hd400, 8'h00, 0, 0, 0, 12'h000, 0, 8'h00, 1, 21'h1ff800},
    '{16'he080, 8'h00, 1, 0, 0, 12'h000, 0, 8'h00, 1, 21'h1fff00},
    '{16'he005, 8'h00, 0, 1, 0, 12'h000, 0, 8'h00, 0, 0},
    '{16'he47f, 8'h00, 0, 1, 0, 12'h000, 0, 8'h00, 1, 21'h0000fe},
    '{16'he47f, 8'h00, 1, 0, 0, 12'h000, 0, 8'h00, 0, 0}
  };

  branch_bit_call_decode dut (
    .clk_i, .nrst_i, .instr_i, .instr_valid_i, .flag_zero_i, .flag_ovf_i,
    .working_i, .flags_i, .bank_select_reg_i, .file_rdata_i, .file_addr_o,
    .file_rd_o, .file_we_o, .file_wdata_o, .pc_o, .flush_o, .stack_push_o,
    .return_stack_top_o, .quarter_o, .working_shadow_o, .flags_shadow_o,
    .bank_select_shadow_o, .status_we_o
  );

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one instruction cycle; the result of the previous word shows at its q0
  task automatic step(input logic [15:0] w, input logic v,
                      input logic [7:0] rd, input logic z, ov);
    int n;
    n = 0;
    while (quarter_o !== 2'h3 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (quarter_o !== 2'h3) errors++;
    @(posedge clk_i);
    instr_i       <= w;
    instr_valid_i <= v;
    file_rdata_i  <= rd;
    flag_zero_i   <= z;
    flag_ovf_i    <= ov;
    @(negedge clk_i);
    end_pc = pc_o;
    end_fl = flush_o;
    @(negedge clk_i);
    rd_s   = file_rd_o;
    addr_s = file_addr_o;
    pc1    = pc_o;
    repeat (2) @(negedge clk_i);
    we_s   = file_we_o;
    wd_s   = file_wdata_o;
    push_s = stack_push_o;
    tos_s  = return_stack_top_o;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog and sequence
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    results();
  end

  initial begin
    {instr_i, instr_valid_i, flag_zero_i, flag_ovf_i, nrst_i} = '0;
    {working_i, flags_i, file_rdata_i} = '0;
    bank_select_reg_i = 4'h5;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check("pc_reset", pc_o, 0);
    foreach (rows[i]) begin
      step(rows[i].w, 1, rows[i].rd, rows[i].z, rows[i].ov);
      if (rows[i].erd) check("file_addr", addr_s, rows[i].addr);
      check("file_we", we_s, rows[i].we);
      if (rows[i].we) check("file_wdata", wd_s, rows[i].wd);
      p = pc1 + rows[i].pcd;
      step(16'h0, 0, 8'h0, 0, 0);
      check("flush", end_fl, rows[i].fl);
      if (rows[i].w[15:13] != 3'b101) check("pc", end_pc, p);
    end
    @(posedge clk_i);
    working_i         <= 8'h3c;
    flags_i           <= 8'h5a;
    bank_select_reg_i <= 4'h9;
    // step must not read the quarter in the time step of an edge
    @(negedge clk_i);
    step(16'hedde, 1, 8'h0, 0, 0);
    check("push", push_s, 1);
    check("tos", tos_s, pc1 + 21'h2);
    check("ws", {working_shadow_o, flags_shadow_o}, 16'h3c5a);
    check("bss", bank_select_shadow_o, 4'h9);
    step(16'hfabc, 1, 8'h0, 0, 0);
    step(16'h0, 0, 8'h0, 0, 0);
    check("call_pc", end_pc, 21'h1579bc);
    @(posedge clk_i);
    working_i <= 8'h11;
    @(negedge clk_i);
    step(16'hec01, 1, 8'h0, 0, 0);
    check("ws_kept", working_shadow_o, 8'h3c);
    step(16'hf000, 1, 8'h0, 0, 0);
    step(16'h0, 0, 8'h0, 0, 0);
    check("call_pc", end_pc, 21'h000002);
    step(16'hb220, 1, 8'h00, 0, 0);
    step(16'hed00, 1, 8'h00, 0, 0);
    check("victim_push", push_s, 0);
    step(16'h8e0a, 1, 8'h00, 0, 0);
    check("idle_rd", rd_s, 0);
    step(16'h8e0a, 1, 8'h00, 0, 0);
    check("resume_rd", rd_s, 1);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    @(negedge clk_i);
    check("rst_pc", pc_o, 0);
    check("rst_tos", return_stack_top_o, 0);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    // first word after release must run from a clean quarter count
    step(16'h8e0a, 1, 8'h0a, 0, 0);
    check("rst_we", we_s, 1);
    check("rst_wdata", wd_s, 8'h8a);
    check("rst_pc1", pc1, 21'h000004);
    results();
  end
endmodule // branch_bit_call_decode_tb

bind branch_bit_call_decode branch_bit_call_decode_sva chk (
  .clk_i, .nrst_i, .file_rd_o, .file_we_o, .file_addr_o, .pc_o, .flush_o,
  .stack_push_o, .return_stack_top_o, .quarter_o, .status_we_o
);
